// File: serial_control_pkg.sv
// Constants shared by the serial control enable block
package serial_control_pkg;
	// Register word indices (byte offset / 4) on the Avalon-MM slave
	localparam logic [2:0] IDX_CONTROL = 3'h0; // serial_control at 0x00
	localparam logic [2:0] IDX_FORMAT  = 3'h1; // serial_format_reg at 0x04
	localparam logic [2:0] IDX_FLAGS   = 3'h2; // serial_flags_reg at 0x08
	localparam logic [2:0] IDX_EVENTS  = 3'h3; // Sticky event status 0x0c
	localparam logic [2:0] IDX_MASK    = 3'h4; // Event mask at 0x10
	// serial_control bit positions
	localparam int B_TX_EMPTY_IRQ_ON = 7;
	localparam int B_RX_IRQ_ON       = 6;
	localparam int B_TX_ON           = 5;
	localparam int B_RX_ON           = 4;
	localparam int B_ADDR_FILTER     = 3;
	localparam int B_TX_DONE_IRQ_ON  = 2;
	localparam int B_CLK_SRC_HI      = 1;
	localparam int B_CLK_SRC_LO      = 0;
	// serial_format_reg bit positions
	localparam int B_COMM_SYNC      = 7;
	localparam int B_MULTIPROC_MODE = 2;
	// serial_flags_reg bit positions
	localparam int B_TX_EMPTY_FLAG   = 7;
	localparam int B_RX_FULL_FLAG    = 6;
	localparam int B_OVERRUN_FLAG    = 5;
	localparam int B_FRAMING_ERR     = 4;
	localparam int B_TX_DONE_FLAG    = 2;
	localparam int B_RX_ADDR_BIT     = 1;
	// Event status / mask bit positions
	localparam int E_RX_ACCEPT = 0;
	localparam int E_RX_ERROR  = 1;
	localparam int E_TX_EMPTY  = 2;
	localparam int E_TX_DONE   = 3;
	localparam int E_ADDR_HIT  = 4;
	localparam int EVENT_W     = 5;
	// Values after reset
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] FORMAT_RST  = 8'h00;
	localparam logic [EVENT_W-1:0] EVENTS_RST = 5'h00;
	localparam logic [EVENT_W-1:0] MASK_RST   = 5'h00;
	// Clock-source codes
	typedef enum logic [1:0] {
		CLK_INT     = 2'b00,
		CLK_INT_OUT = 2'b01,
		CLK_EXT     = 2'b10,
		CLK_RSVD    = 2'b11
	} clk_src_t;
endpackage

// File: serial_control_enables.sv
// Serial unit control register with enables, filter, clock select and irqs
// What this block does
// - Transmit-empty request is raised only while bit 7 is set.
// - Bit 6 gates both receive-full and receive-error requests.
// - Transmission runs only while bit 5 is one.
// - Reception runs only while bit 4 is one.
// - Address filter discards multiprocessor-bit-zero characters without setting flags.
// - A multiprocessor-bit-one character clears the filter bit and resumes reception.
// - Filter acts only in asynchronous mode with multiprocessor mode selected.
// - Transmit-done request is raised only while bit 2 is set.
// - Asynchronous codes 00 and 01 use internal clock; 01 outputs bit clock.
// - Asynchronous code 10 takes a sixteen-times clock from the pin.
// - Synchronous code 00 drives the internal transfer clock out on the pin.
// - Synchronous code 10 makes the pin an input; 01 and 11 reserved.
// - Format bit 7 selects asynchronous when 0, synchronous when 1.
// - While transmitter is off, tx-empty and tx-done flags are held set.
// - Clearing the receiver-on bit leaves the received address bit unchanged.
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module serial_control_enables
	import serial_control_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// Avalon-MM slave
	input  wire logic [4:0]  ADDRESS,
	input  wire logic        READ,
	input  wire logic        WRITE,
	input  wire logic [3:0]  BYTEENABLE,
	input  wire logic [31:0] WRITEDATA,
	output logic      [31:0] READDATA,
	output logic             WAITREQUEST,
	// Datapath events, same clock
	input  wire logic        TX_DATA_WRITE,
	input  wire logic        TX_LOAD,
	input  wire logic        TX_LAST_BIT,
	input  wire logic        RX_DONE,
	input  wire logic        RX_MPB,
	input  wire logic        RX_FRAME_ERR,
	input  wire logic        RX_OVERRUN,
	input  wire logic        RX_DATA_READ,
	input  wire logic        BIT_HALF_TICK,
	// Serial clock pin
	input  wire logic        SERIAL_CLK_PIN_I,
	output logic             SERIAL_CLK_PIN_O,
	output logic             SERIAL_CLK_PIN_OE,
	// Datapath controls
	output logic             TX_RUN,
	output logic             RX_RUN,
	output logic             EXT_CLK_SEL,
	output logic             EXT_CLK_RISE,
	// Interrupt requests
	output logic             TX_EMPTY_IRQ,
	output logic             RX_FULL_IRQ,
	output logic             RX_ERROR_IRQ,
	output logic             TX_DONE_IRQ,
	output logic             IRQ
);
	import serial_control_pkg::*;

	// Register state
	logic [7:0]         serial_control_q;
	logic [7:0]         serial_format_q;
	logic               tx_empty_flag_q;
	logic               rx_full_flag_q;
	logic               overrun_flag_q;
	logic               framing_err_flag_q;
	logic               tx_done_flag_q;
	logic               rx_addr_bit_q;
	logic [EVENT_W-1:0] events_q;
	logic [EVENT_W-1:0] mask_q;
	logic               wait_q;
	logic [31:0]        rdata_q;
	logic               sync1_q;
	logic               sync2_q;
	logic               sync3_q;
	logic               sck_q;
	logic               sck_oe_q;
	logic               ext_sel_q;
	logic               ext_rise_q;
	logic               tx_empty_irq_q;
	logic               rx_full_irq_q;
	logic               rx_error_irq_q;
	logic               tx_done_irq_q;
	logic               irq_q;

	// Field views of the control and format registers
	wire logic tx_empty_irq_on = serial_control_q[B_TX_EMPTY_IRQ_ON];
	wire logic rx_irq_on       = serial_control_q[B_RX_IRQ_ON];
	wire logic tx_on           = serial_control_q[B_TX_ON];
	wire logic rx_on           = serial_control_q[B_RX_ON];
	wire logic addr_filter     = serial_control_q[B_ADDR_FILTER];
	wire logic tx_done_irq_on  = serial_control_q[B_TX_DONE_IRQ_ON];
	wire logic comm_sync       = serial_format_q[B_COMM_SYNC];
	wire logic multiproc_mode  = serial_format_q[B_MULTIPROC_MODE];
	wire clk_src_t clk_src     = clk_src_t'(
		serial_control_q[B_CLK_SRC_HI:B_CLK_SRC_LO]);

	// Bus decode: request accepted at the edge where waitrequest is low
	wire logic [2:0] reg_idx   = ADDRESS[4:2];
	wire logic       bus_go    = (READ | WRITE) & ~wait_q;
	wire logic       wr_lane0  = WRITE & ~wait_q & BYTEENABLE[0];
	wire logic       wr_ctrl   = wr_lane0 & (reg_idx == IDX_CONTROL);
	wire logic       wr_fmt    = wr_lane0 & (reg_idx == IDX_FORMAT);
	wire logic       wr_flags  = wr_lane0 & (reg_idx == IDX_FLAGS);
	wire logic       wr_mask   = wr_lane0 & (reg_idx == IDX_MASK);
	wire logic       rd_events = READ & ~wait_q & (reg_idx == IDX_EVENTS);

	// Flag clears by writing 0 to the flag position
	wire logic clr_tx_empty = wr_flags & ~WRITEDATA[B_TX_EMPTY_FLAG];
	wire logic clr_rx_full  = wr_flags & ~WRITEDATA[B_RX_FULL_FLAG];
	wire logic clr_overrun  = wr_flags & ~WRITEDATA[B_OVERRUN_FLAG];
	wire logic clr_framing  = wr_flags & ~WRITEDATA[B_FRAMING_ERR];

	// Receive acceptance with the multiprocessor address filter
	wire logic filter_live = addr_filter & multiproc_mode & ~comm_sync;
	wire logic rx_take     = RX_DONE & rx_on;
	wire logic rx_drop     = rx_take & filter_live & ~RX_MPB;
	wire logic rx_accept   = rx_take & ~rx_drop;
	wire logic addr_hit    = rx_take & filter_live & RX_MPB;
	wire logic set_fer     = rx_accept & RX_FRAME_ERR;
	wire logic set_ovr     = rx_accept & RX_OVERRUN;

	// Transmit flag events
	wire logic tx_load_ev = TX_LOAD & tx_on;
	wire logic tx_done_ev = TX_LAST_BIT & tx_on & tx_empty_flag_q;

	// Next control value: hardware clear of the filter bit wins
	logic [7:0] control_d;
	always_comb begin
		control_d = wr_ctrl ? WRITEDATA[7:0] : serial_control_q;
		if (addr_hit)
			control_d[B_ADDR_FILTER] = 1'b0;
	end

	// Clock-source decode per communication mode
	wire logic drive_clk = comm_sync ? (clk_src == CLK_INT)
	                                 : (clk_src == CLK_INT_OUT);
	wire logic use_ext   = (clk_src == CLK_EXT);

	// Event set terms; a read clears only the bits it returned, set wins
	wire logic [EVENT_W-1:0] ev_set = {addr_hit, tx_done_ev, tx_load_ev,
	                                   set_fer | set_ovr, rx_accept};
	wire logic [EVENT_W-1:0] rd_seen  = rd_events ? rdata_q[EVENT_W-1:0]
	                                              : {EVENT_W{1'b0}};
	wire logic [EVENT_W-1:0] events_d = (events_q & ~rd_seen) | ev_set;

	// Read mux, registered at the edge that raises the answer
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (reg_idx)
			IDX_CONTROL: rd_mux[7:0] = serial_control_q;
			IDX_FORMAT:  rd_mux[7:0] = serial_format_q;
			IDX_FLAGS: begin
				rd_mux[B_TX_EMPTY_FLAG] = tx_empty_flag_q;
				rd_mux[B_RX_FULL_FLAG]  = rx_full_flag_q;
				rd_mux[B_OVERRUN_FLAG]  = overrun_flag_q;
				rd_mux[B_FRAMING_ERR]   = framing_err_flag_q;
				rd_mux[B_TX_DONE_FLAG]  = tx_done_flag_q;
				rd_mux[B_RX_ADDR_BIT]   = rx_addr_bit_q;
			end
			IDX_EVENTS:  rd_mux[EVENT_W-1:0] = events_q;
			IDX_MASK:    rd_mux[EVENT_W-1:0] = mask_q;
			default:     rd_mux = 32'h0000_0000;
		endcase
	end

	// Avalon handshake: one wait cycle, then a one-cycle answer
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~((READ | WRITE) & wait_q);
			if (READ & wait_q)
				rdata_q <= rd_mux;
		end
	end

	// Control, format and mask registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			serial_control_q <= CONTROL_RST;
			serial_format_q  <= FORMAT_RST;
			mask_q           <= MASK_RST;
		end else begin
			serial_control_q <= control_d;
			if (wr_fmt)
				serial_format_q <= WRITEDATA[7:0];
			if (wr_mask)
				mask_q <= WRITEDATA[EVENT_W-1:0];
		end
	end

	// Transmit flags, held set while the transmitter is off
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_empty_flag_q <= 1'b1;
			tx_done_flag_q  <= 1'b1;
		end else begin
			tx_empty_flag_q <= ~tx_on | tx_load_ev
			                 | (tx_empty_flag_q & ~clr_tx_empty
			                    & ~TX_DATA_WRITE);
			tx_done_flag_q  <= ~tx_on | tx_done_ev
			                 | (tx_done_flag_q & ~TX_DATA_WRITE);
		end
	end

	// Receive flags, set only by accepted characters
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_full_flag_q     <= 1'b0;
			overrun_flag_q     <= 1'b0;
			framing_err_flag_q <= 1'b0;
			rx_addr_bit_q      <= 1'b0;
		end else begin
			rx_full_flag_q     <= rx_accept
			                    | (rx_full_flag_q & ~clr_rx_full
			                       & ~RX_DATA_READ);
			overrun_flag_q     <= set_ovr | (overrun_flag_q & ~clr_overrun);
			framing_err_flag_q <= set_fer | (framing_err_flag_q
			                                 & ~clr_framing);
			if (rx_take)
				rx_addr_bit_q <= RX_MPB;
		end
	end

	// Serial clock pin: synchroniser and rising-edge detect
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_q    <= 1'b0;
			sync2_q    <= 1'b0;
			sync3_q    <= 1'b0;
			ext_sel_q  <= 1'b0;
			ext_rise_q <= 1'b0;
		end else begin
			sync1_q    <= SERIAL_CLK_PIN_I;
			sync2_q    <= sync1_q;
			sync3_q    <= sync2_q;
			ext_sel_q  <= use_ext;
			ext_rise_q <= use_ext & sync2_q & ~sync3_q;
		end
	end

	// Serial clock out: bit-rate clock toggled each half bit
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sck_q    <= 1'b1;
			sck_oe_q <= 1'b0;
		end else begin
			sck_oe_q <= drive_clk;
			if (!drive_clk)
				sck_q <= 1'b1;
			else if (BIT_HALF_TICK)
				sck_q <= ~sck_q;
		end
	end

	// Gated interrupt requests and sticky events
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_empty_irq_q <= 1'b0;
			rx_full_irq_q  <= 1'b0;
			rx_error_irq_q <= 1'b0;
			tx_done_irq_q  <= 1'b0;
			events_q       <= EVENTS_RST;
			irq_q          <= 1'b0;
		end else begin
			tx_empty_irq_q <= tx_empty_irq_on & tx_empty_flag_q;
			rx_full_irq_q  <= rx_irq_on & rx_full_flag_q;
			rx_error_irq_q <= rx_irq_on
			                & (overrun_flag_q | framing_err_flag_q);
			tx_done_irq_q  <= tx_done_irq_on & tx_done_flag_q;
			events_q       <= events_d;
			irq_q          <= |(events_d & mask_q);
		end
	end

	// Outputs straight from flip-flops
	assign READDATA          = rdata_q;
	assign WAITREQUEST       = wait_q;
	assign SERIAL_CLK_PIN_O  = sck_q;
	assign SERIAL_CLK_PIN_OE = sck_oe_q;
	assign TX_RUN            = tx_on;
	assign RX_RUN            = rx_on;
	assign EXT_CLK_SEL       = ext_sel_q;
	assign EXT_CLK_RISE      = ext_rise_q;
	assign TX_EMPTY_IRQ      = tx_empty_irq_q;
	assign RX_FULL_IRQ       = rx_full_irq_q;
	assign RX_ERROR_IRQ      = rx_error_irq_q;
	assign TX_DONE_IRQ       = tx_done_irq_q;
	assign IRQ               = irq_q;

	// Unused bus bits
	wire logic unused_ok = &{1'b0, ADDRESS[1:0], BYTEENABLE[3:1],
	                         WRITEDATA[31:8], bus_go};
endmodule // serial_control_enables
`default_nettype wire

// File: serial_control_enables_properties.sv
// Port-level checks for the serial control enable block
`timescale 1ns/1ps
`default_nettype none
module serial_control_enables_checker (
	// Clock, reset and bus handshake
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic WRITE,
	input wire logic WAITREQUEST,
	// Datapath events
	input wire logic TX_LOAD,
	input wire logic TX_LAST_BIT,
	input wire logic RX_DONE,
	// Pin and datapath controls
	input wire logic SERIAL_CLK_PIN_O,
	input wire logic SERIAL_CLK_PIN_OE,
	input wire logic TX_RUN,
	input wire logic RX_RUN,
	input wire logic EXT_CLK_SEL,
	input wire logic EXT_CLK_RISE,
	// Interrupt requests
	input wire logic TX_EMPTY_IRQ,
	input wire logic RX_FULL_IRQ,
	input wire logic RX_ERROR_IRQ,
	input wire logic TX_DONE_IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic acc;
	// A register write takes effect at this edge
	assign acc = WRITE && !WAITREQUEST;
	// Enables and requests are all off right after reset
	property p_rst_vals;
		$rose(RST_N) |-> !TX_RUN && !RX_RUN && !SERIAL_CLK_PIN_OE && !TX_EMPTY_IRQ
			&& !RX_FULL_IRQ && !RX_ERROR_IRQ && !TX_DONE_IRQ;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
	property p_run_chg;
		$changed({TX_RUN, RX_RUN}) |-> $past(acc);
	endproperty
	a_run_chg: assert property (p_run_chg) else $error("run changed w/o write");
	property p_oe_ext;
		EXT_CLK_SEL |-> !SERIAL_CLK_PIN_OE;
	endproperty
	a_oe_ext: assert property (p_oe_ext) else $error("pin driven on ext clock");
	property p_idle_high;
		!SERIAL_CLK_PIN_OE |-> SERIAL_CLK_PIN_O;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("clock out not idle");
	property p_ext_rise;
		EXT_CLK_RISE |-> EXT_CLK_SEL || $past(EXT_CLK_SEL);
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("edge w/o ext clock");
	property p_rx_irq;
		$rose(RX_FULL_IRQ) |-> $past(RX_DONE, 2) || $past(acc, 2);
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx request w/o cause");
	property p_txe_irq;
		$rose(TX_EMPTY_IRQ) |-> $past(TX_LOAD, 2) || $past(acc, 2)
			|| $past(acc, 3);
	endproperty
	a_txe_irq: assert property (p_txe_irq) else $error("tx empty req w/o cause");
	property p_txd_irq;
		$rose(TX_DONE_IRQ) |-> $past(TX_LAST_BIT, 2) || $past(acc, 2)
			|| $past(acc, 3);
	endproperty
	a_txd_irq: assert property (p_txd_irq) else $error("tx done req w/o cause");
	// Main scenarios reached
	c_ext: cover property ($rose(EXT_CLK_RISE));
	c_rx: cover property ($rose(RX_FULL_IRQ));
	c_clk: cover property ($fell(SERIAL_CLK_PIN_O));
endmodule // serial_control_enables_checker
bind serial_control_enables serial_control_enables_checker
	u_serial_control_enables_checker (.CLK(CLK), .RST_N(RST_N),
	.WRITE(WRITE), .WAITREQUEST(WAITREQUEST), .TX_LOAD(TX_LOAD),
	.TX_LAST_BIT(TX_LAST_BIT), .RX_DONE(RX_DONE),
	.SERIAL_CLK_PIN_O(SERIAL_CLK_PIN_O), .SERIAL_CLK_PIN_OE(SERIAL_CLK_PIN_OE),
	.TX_RUN(TX_RUN), .RX_RUN(RX_RUN), .EXT_CLK_SEL(EXT_CLK_SEL),
	.EXT_CLK_RISE(EXT_CLK_RISE), .TX_EMPTY_IRQ(TX_EMPTY_IRQ),
	.RX_FULL_IRQ(RX_FULL_IRQ), .RX_ERROR_IRQ(RX_ERROR_IRQ),
	.TX_DONE_IRQ(TX_DONE_IRQ));
`default_nettype wire

// File: serial_peer_model.sv
// Far serial station: supplies the pin clock or watches the device drive it
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Serial clock pin
	input  wire logic ext_want,
	input  wire logic pin_oe,
	input  wire logic pin_o,
	output logic      pin_i
);
	logic [1:0] div_q;
	logic       ext_q;
	// Sixteen-times clock, a period of eight system cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 2'h0;
			ext_q <= 1'b0;
		end else begin
			div_q <= div_q + 2'h1;
			if (div_q == 2'h3) ext_q <= ~ext_q;
		end
	end
	// Device drive wins; an undriven pin shows a changing pattern
	assign pin_i = pin_oe ? pin_o : (ext_want ? ext_q : div_q[0]);
endmodule // serial_peer_model
`default_nettype wire

// File: tb_serial_control_enables.sv
// Self-checking bench for the serial control enable block
`timescale 1ns/1ps
`default_nettype none
module tb_serial_control_enables;
	import serial_control_pkg::*;
	logic        clk, rst_n, rd, wr, waitreq, pin_i, pin_o, pin_oe;
	logic [4:0]  address;
	logic [31:0] wdata, rdata, rdat;
	logic [8:0]  ev_q;
	logic [3:0]  byteen, be_q;
	logic        tx_run, rx_run, ext_sel, ext_rise, irq;
	logic        txe_irq, rxf_irq, rxe_irq, txd_irq, oe;
	int          n_fail = 0;
	int          check_count = 0;
	int          c;
	serial_control_enables u_serial_control_enables (.CLK(clk), .RST_N(rst_n),
		.ADDRESS(address), .READ(rd), .WRITE(wr), .BYTEENABLE(byteen),
		.WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(waitreq),
		.TX_DATA_WRITE(ev_q[8]), .TX_LOAD(ev_q[7]), .TX_LAST_BIT(ev_q[6]),
		.RX_DONE(ev_q[5]), .RX_MPB(ev_q[4]), .RX_FRAME_ERR(ev_q[3]),
		.RX_OVERRUN(ev_q[2]), .RX_DATA_READ(ev_q[1]), .BIT_HALF_TICK(ev_q[0]),
		.SERIAL_CLK_PIN_I(pin_i), .SERIAL_CLK_PIN_O(pin_o),
		.SERIAL_CLK_PIN_OE(pin_oe), .TX_RUN(tx_run), .RX_RUN(rx_run),
		.EXT_CLK_SEL(ext_sel), .EXT_CLK_RISE(ext_rise), .TX_EMPTY_IRQ(txe_irq),
		.RX_FULL_IRQ(rxf_irq), .RX_ERROR_IRQ(rxe_irq), .TX_DONE_IRQ(txd_irq),
		.IRQ(irq));
	serial_peer_model u_serial_peer_model (.clk(clk), .rst_n(rst_n),
		.ext_want(ext_sel), .pin_oe(pin_oe), .pin_o(pin_o), .pin_i(pin_i));
	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d);
		logic timed_out;
		c = 0;
		@(posedge clk);
		address <= {i, 2'b00};
		byteen <= be_q;
		wr <= w;
		rd <= !w;
		wdata <= {24'h0, d};
		do begin
			@(posedge clk);
			c++;
		end while (waitreq !== 1'b0 && c < 20);
		rdat = rdata;
		timed_out = (waitreq !== 1'b0);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		if (timed_out) begin
			n_fail++;
			final_report();
		end
	endtask
	// Read a register and compare its byte
	task automatic rchk(input string nm, input logic [2:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(nm, {24'h0, e}, rdat);
	endtask
	// One-cycle datapath event, then wait for the requests to follow
	task automatic ev(input logic [8:0] v);
		@(posedge clk);
		ev_q <= v;
		@(posedge clk);
		ev_q <= 9'h000;
		@(posedge clk);
		#1;
	endtask
	// System clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{rd, wr, address, wdata, ev_q} = '0;
		byteen = 4'h1;
		be_q = 4'h1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rchk("control", IDX_CONTROL, CONTROL_RST);
		rchk("flags", IDX_FLAGS, 8'h84);
		bus(1'b1, 3'h5, 8'hff);
		rchk("unmapped", 3'h5, 8'h00);
		// A write without byte lane 0 is ignored
		be_q = 4'h0;
		bus(1'b1, IDX_CONTROL, 8'h30);
		be_q = 4'h1;
		rchk("control", IDX_CONTROL, 8'h00);
		bus(1'b1, IDX_CONTROL, 8'h30);
		chk("tx_run", 1, tx_run);
		chk("rx_run", 1, rx_run);
		ev(9'h100);
		rchk("flags", IDX_FLAGS, 8'h00);
		ev(9'h080);
		chk("txe_irq", 0, txe_irq);
		bus(1'b1, IDX_CONTROL, 8'hb0);
		ev(9'h040);
		chk("txe_irq", 1, txe_irq);
		chk("txd_irq", 0, txd_irq);
		bus(1'b1, IDX_CONTROL, 8'hb4);
		ev(9'h000);
		chk("txd_irq", 1, txd_irq);
		bus(1'b1, IDX_CONTROL, 8'h04);
		ev(9'h100);
		rchk("flags", IDX_FLAGS, 8'h84);
		bus(1'b1, IDX_FORMAT, 8'h04);
		bus(1'b1, IDX_CONTROL, 8'h18);
		ev(9'h028);
		rchk("flags", IDX_FLAGS, 8'h84);
		rchk("control", IDX_CONTROL, 8'h18);
		ev(9'h030);
		rchk("control", IDX_CONTROL, 8'h10);
		rchk("flags", IDX_FLAGS, 8'hc6);
		chk("rxf_irq", 0, rxf_irq);
		bus(1'b1, IDX_CONTROL, 8'h50);
		ev(9'h02c);
		chk("rxf_irq", 1, rxf_irq);
		chk("rxe_irq", 1, rxe_irq);
		rchk("flags", IDX_FLAGS, 8'hf4);
		bus(1'b1, IDX_FLAGS, 8'h00);
		rchk("flags", IDX_FLAGS, 8'h84);
		bus(1'b1, IDX_FORMAT, 8'h84);
		bus(1'b1, IDX_CONTROL, 8'h18);
		ev(9'h020);
		rchk("flags", IDX_FLAGS, 8'hc4);
		ev(9'h030);
		bus(1'b1, IDX_CONTROL, 8'h00);
		ev(9'h020);
		rchk("flags", IDX_FLAGS, 8'hc6);
		ev(9'h002);
		rchk("flags", IDX_FLAGS, 8'h86);
		// Sticky events against the mask
		bus(1'b0, IDX_EVENTS, 8'h00);
		bus(1'b1, IDX_MASK, 8'h01);
		bus(1'b1, IDX_CONTROL, 8'h10);
		ev(9'h020);
		chk("irq", 1, irq);
		rchk("events", IDX_EVENTS, 8'h01);
		chk("irq", 0, irq);
		bus(1'b1, IDX_MASK, 8'h00);
		ev(9'h020);
		chk("irq", 0, irq);
		// Every clock-select code in both communication modes
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, IDX_FORMAT, {s[2], 7'h00});
			bus(1'b1, IDX_CONTROL, {6'h00, s[1:0]});
			ev(9'h001);
			oe = s[2] ? (s[1:0] == 2'b00) : (s[1:0] == 2'b01);
			chk("pin_oe", oe, pin_oe);
			chk("pin_o", !oe, pin_o);
			chk("ext_sel", s[1:0] == 2'b10, ext_sel);
		end
		bus(1'b1, IDX_FORMAT, 8'h00);
		bus(1'b1, IDX_CONTROL, 8'h02);
		c = 0;
		while (ext_rise !== 1'b1 && c < 40) begin
			@(posedge clk);
			c++;
		end
		chk("ext_rise", 1, ext_rise);
		final_report();
	end
endmodule // tb_serial_control_enables
`default_nettype wire
